//--- hw/mrd_pkg.sv
package mrd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on the control bus
  localparam logic [7:0] MRD_REG_CTRL       = 8'h00;
  localparam logic [7:0] MRD_REG_STATE      = 8'h04;
  localparam logic [7:0] MRD_REG_DESC_ADDR  = 8'h08;
  localparam logic [7:0] MRD_REG_BUF_ADDR   = 8'h0c;
  localparam logic [7:0] MRD_REG_CACHE_USER = 8'h10;
  localparam logic [7:0] MRD_REG_STRIDE_CNT = 8'h14;
  localparam logic [7:0] MRD_REG_LINE_SIZE  = 8'h18;
  localparam logic [7:0] MRD_REG_LAST_STS   = 8'h1c;

  // Control register bits (write-one pulses)
  localparam int MRD_CTRL_START_BIT = 0;
  localparam int MRD_CTRL_CLEAR_BIT = 1;

  // State register bits
  localparam int MRD_STATE_BUSY_BIT   = 0;
  localparam int MRD_STATE_HALTED_BIT = 1;
  localparam int MRD_STATE_DONE_BIT   = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Descriptor field layout
  localparam int MRD_CACHE_LSB  = 24;
  localparam int MRD_USERW_LSB  = 28;
  localparam int MRD_STRIDE_LSB = 0;
  localparam int MRD_LCOUNT_LSB = 19;
  localparam int MRD_LCOUNT_W   = 13;

  // Status word is written at descriptor base plus this offset
  localparam logic [31:0] MRD_STS_OFFSET = 32'h0000_001c;

  // Status word bit positions
  localparam int MRD_STS_DEST_LSB = 0;
  localparam int MRD_STS_ID_LSB   = 8;
  localparam int MRD_STS_USER_LSB = 16;
  localparam int MRD_STS_EOP_BIT  = 26;
  localparam int MRD_STS_SOP_BIT  = 27;
  localparam int MRD_STS_IE_BIT   = 28;
  localparam int MRD_STS_SE_BIT   = 29;
  localparam int MRD_STS_DE_BIT   = 30;
  localparam int MRD_STS_CMP_BIT  = 31;

  // Memory write responses
  localparam logic [1:0] MRD_RESP_SLVERR = 2'h2;
  localparam logic [1:0] MRD_RESP_DECERR = 2'h3;

  localparam logic [31:0] MRD_BEAT_BYTES = 32'h0000_0004;
  localparam int          MRD_FIFO_DEPTH = 32;

  // Reset values
  localparam logic [31:0] MRD_RST_WORD = 32'h0000_0000;

  typedef struct packed {
    logic [31:0] data;
    logic        last;
    logic [4:0]  dest;
    logic [4:0]  id;
    logic [3:0]  user;
  } mrd_beat_type;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0]  cache;
    logic [3:0]  user;
  } mrd_wr_req_type;

endpackage : mrd_pkg

//--- hw/mrd_rx_status.sv
// Functional notes
// - Line size counts bytes per horizontal line.
// - Capture routing value into status bits 4:0.
// - Capture stream identifier into status bits 12:8.
// - Capture user sideband into status bits 19:16.
// - End-of-packet flag marks buffer whose packet end completes its last line.
// - Begin-of-packet flag marks buffer with packet start.
// - Under-run or over-run sets internal error, halts.
// - Target slave error sets bit 29, halts.
// - Address decode error sets bit 30, halts.
// - Completion bit set once descriptor finished.
// - Line count from bits 31:19 per descriptor.
// - Next line starts at previous start plus stride.
// - Cache bits driven on every write address.
// - Status written only after all data writes.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Stream buffer
module mrd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0]      wr_ptr_ff;
  logic [AW:0]      rd_ptr_ff;
  logic [AW:0]      nxt_wr_ptr;
  logic [AW:0]      nxt_rd_ptr;
  logic             full;
  logic             empty;

  assign full        = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                       (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
  assign empty       = (wr_ptr_ff == rd_ptr_ff);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem_ff[rd_ptr_ff[AW-1:0]];

  always_comb begin
    nxt_wr_ptr = wr_ptr_ff;
    nxt_rd_ptr = rd_ptr_ff;
    if (in_valid_i && !full) begin
      nxt_wr_ptr = wr_ptr_ff + 1'b1;
    end
    if (out_ready_i && !empty) begin
      nxt_rd_ptr = rd_ptr_ff + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
    end
  end

  // Storage needs no reset; pointers guard every read
  always_ff @(posedge clk_i) begin
    if (in_valid_i && !full) begin
      mem_ff[wr_ptr_ff[AW-1:0]] <= in_data_i;
    end
  end
endmodule : mrd_fifo

////////////////////////////////////////////////////////////////////////////////
// Receive descriptor engine with status write-back
module mrd_rx_status
  import mrd_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Incoming packet stream
  input  wire logic [31:0] s_tdata_i,
  input  wire logic        s_tvalid_i,
  input  wire logic        s_tlast_i,
  input  wire logic [4:0]  s_tdest_i,
  input  wire logic [4:0]  s_tid_i,
  input  wire logic [3:0]  s_tuser_i,
  output logic             s_tready_o,
  // Memory write port: address and data travel together
  output logic [31:0]      m_awaddr_o,
  output logic [3:0]       m_awcache_o,
  output logic [3:0]       m_awuser_o,
  output logic [31:0]      m_wdata_o,
  output logic             m_valid_o,
  input  wire logic        m_ready_i,
  input  wire logic        m_bvalid_i,
  input  wire logic [1:0]  m_bresp_i,
  output logic             m_bready_o
);

  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_DATA  = 8'h02,
    ST_WRITE = 8'h04,
    ST_RESP  = 8'h08,
    ST_STS   = 8'h10,
    ST_SRESP = 8'h20,
    ST_HALT  = 8'h40,
    ST_PREP  = 8'h80
  } mrd_state_type;

  //////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [31:0] desc_addr_ff,  nxt_desc_addr;
  logic [31:0] buf_addr_ff,   nxt_buf_addr;
  logic [31:0] cache_user_ff, nxt_cache_user;
  logic [31:0] stride_cnt_ff, nxt_stride_cnt;
  logic [31:0] line_size_ff,  nxt_line_size;
  logic [31:0] rd_data_ff,    nxt_rd_data;
  logic        ack_ff,        nxt_ack;
  logic        start_req;
  logic        clear_req;
  logic        req;
  logic        done_ff;
  logic [31:0] last_sts_ff;
  mrd_state_type state_ff;

  assign req      = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rd_data_ff;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  always_comb begin
    nxt_desc_addr  = desc_addr_ff;
    nxt_buf_addr   = buf_addr_ff;
    nxt_cache_user = cache_user_ff;
    nxt_stride_cnt = stride_cnt_ff;
    nxt_line_size  = line_size_ff;
    nxt_rd_data    = rd_data_ff;
    nxt_ack        = req;
    start_req      = 1'b0;
    clear_req      = 1'b0;
    if (req && wb_we_i) begin
      case (wb_adr_i)
        MRD_REG_CTRL: begin
          start_req = wb_sel_i[0] && wb_dat_i[MRD_CTRL_START_BIT];
          clear_req = wb_sel_i[0] && wb_dat_i[MRD_CTRL_CLEAR_BIT];
        end
        MRD_REG_DESC_ADDR:  nxt_desc_addr  = merge(desc_addr_ff,  wb_dat_i, wb_sel_i);
        MRD_REG_BUF_ADDR:   nxt_buf_addr   = merge(buf_addr_ff,   wb_dat_i, wb_sel_i);
        MRD_REG_CACHE_USER: nxt_cache_user = merge(cache_user_ff, wb_dat_i, wb_sel_i);
        MRD_REG_STRIDE_CNT: nxt_stride_cnt = merge(stride_cnt_ff, wb_dat_i, wb_sel_i);
        MRD_REG_LINE_SIZE:  nxt_line_size  = merge(line_size_ff,  wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end else if (req) begin
      case (wb_adr_i)
        MRD_REG_STATE: begin
          nxt_rd_data = '0;
          nxt_rd_data[MRD_STATE_BUSY_BIT]   = (state_ff != ST_IDLE) && (state_ff != ST_HALT);
          nxt_rd_data[MRD_STATE_HALTED_BIT] = (state_ff == ST_HALT);
          nxt_rd_data[MRD_STATE_DONE_BIT]   = done_ff;
        end
        MRD_REG_DESC_ADDR:  nxt_rd_data = desc_addr_ff;
        MRD_REG_BUF_ADDR:   nxt_rd_data = buf_addr_ff;
        MRD_REG_CACHE_USER: nxt_rd_data = {cache_user_ff[31:24], 24'h00_0000};
        MRD_REG_STRIDE_CNT: nxt_rd_data = {stride_cnt_ff[31:19], 3'h0, stride_cnt_ff[15:0]};
        MRD_REG_LINE_SIZE:  nxt_rd_data = {16'h0000, line_size_ff[15:0]};
        MRD_REG_LAST_STS:   nxt_rd_data = last_sts_ff;
        default:            nxt_rd_data = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      desc_addr_ff  <= MRD_RST_WORD;
      buf_addr_ff   <= MRD_RST_WORD;
      cache_user_ff <= MRD_RST_WORD;
      stride_cnt_ff <= MRD_RST_WORD;
      line_size_ff  <= MRD_RST_WORD;
      rd_data_ff    <= MRD_RST_WORD;
      ack_ff        <= 1'b0;
    end else begin
      desc_addr_ff  <= nxt_desc_addr;
      buf_addr_ff   <= nxt_buf_addr;
      cache_user_ff <= nxt_cache_user;
      stride_cnt_ff <= nxt_stride_cnt;
      line_size_ff  <= nxt_line_size;
      rd_data_ff    <= nxt_rd_data;
      ack_ff        <= nxt_ack;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Stream buffer
  mrd_beat_type in_beat;
  mrd_beat_type head;
  logic         head_valid;
  logic         pop;

  assign in_beat = '{data: s_tdata_i, last: s_tlast_i, dest: s_tdest_i,
                     id: s_tid_i, user: s_tuser_i};

  mrd_fifo #(
    .WIDTH ($bits(mrd_beat_type)),
    .DEPTH (MRD_FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_data_i   (in_beat),
    .in_valid_i  (s_tvalid_i),
    .in_ready_o  (s_tready_o),
    .out_data_o  (head),
    .out_valid_o (head_valid),
    .out_ready_i (pop)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Engine
  mrd_wr_req_type           wreq_ff,      nxt_wreq;
  mrd_state_type            nxt_state;
  logic [31:0]              line_base_ff, nxt_line_base;
  logic [15:0]              byte_cnt_ff,  nxt_byte_cnt;
  logic [MRD_LCOUNT_W-1:0]  lines_ff,     nxt_lines;
  logic [4:0]               dest_ff,      nxt_dest;
  logic [4:0]               id_ff,        nxt_id;
  logic [3:0]               user_ff,      nxt_user;
  logic                     beat_last_ff, nxt_beat_last;
  logic                     in_pkt_ff,    nxt_in_pkt;
  logic                     sop_ff,       nxt_sop;
  logic                     eop_ff,       nxt_eop;
  logic                     ie_ff,        nxt_ie;
  logic                     se_ff,        nxt_se;
  logic                     de_ff,        nxt_de;
  logic                     nxt_done;
  logic [31:0]              nxt_last_sts;
  logic [31:0]              sts_word;
  logic [15:0]              next_bytes;
  logic                     line_end;
  logic                     desc_full;

  assign m_awaddr_o  = wreq_ff.addr;
  assign m_wdata_o   = wreq_ff.data;
  assign m_awcache_o = wreq_ff.cache;
  assign m_awuser_o  = wreq_ff.user;
  assign m_valid_o   = (state_ff == ST_WRITE) || (state_ff == ST_STS);
  assign m_bready_o  = (state_ff == ST_RESP) || (state_ff == ST_SRESP);
  assign pop         = (state_ff == ST_DATA) && head_valid;

  assign next_bytes = byte_cnt_ff + MRD_BEAT_BYTES[15:0];
  assign line_end   = next_bytes >= line_size_ff[15:0];
  assign desc_full  = line_end &&
                      (lines_ff + 1'b1 == stride_cnt_ff[MRD_LCOUNT_LSB +: MRD_LCOUNT_W]);

  // Reserved positions stay zero; completion set here since data is done
  always_comb begin
    sts_word                                  = '0;
    sts_word[MRD_STS_DEST_LSB +: 5]           = dest_ff;
    sts_word[MRD_STS_ID_LSB +: 5]             = id_ff;
    sts_word[MRD_STS_USER_LSB +: 4]           = user_ff;
    sts_word[MRD_STS_EOP_BIT]                 = eop_ff;
    sts_word[MRD_STS_SOP_BIT]                 = sop_ff;
    sts_word[MRD_STS_IE_BIT]                  = ie_ff;
    sts_word[MRD_STS_SE_BIT]                  = se_ff;
    sts_word[MRD_STS_DE_BIT]                  = de_ff;
    sts_word[MRD_STS_CMP_BIT]                 = 1'b1;
  end

  always_comb begin
    nxt_state     = state_ff;
    nxt_wreq      = wreq_ff;
    nxt_line_base = line_base_ff;
    nxt_byte_cnt  = byte_cnt_ff;
    nxt_lines     = lines_ff;
    nxt_dest      = dest_ff;
    nxt_id        = id_ff;
    nxt_user      = user_ff;
    nxt_beat_last = beat_last_ff;
    nxt_in_pkt    = in_pkt_ff;
    nxt_sop       = sop_ff;
    nxt_eop       = eop_ff;
    nxt_ie        = ie_ff;
    nxt_se        = se_ff;
    nxt_de        = de_ff;
    nxt_done      = done_ff;
    nxt_last_sts  = last_sts_ff;
    case (state_ff)
      ST_IDLE: begin
        if (start_req) begin
          nxt_wreq.addr = buf_addr_ff;
          nxt_line_base = buf_addr_ff;
          nxt_byte_cnt  = '0;
          nxt_lines     = '0;
          nxt_sop       = !in_pkt_ff;
          nxt_eop       = 1'b0;
          nxt_ie        = 1'b0;
          nxt_se        = 1'b0;
          nxt_de        = 1'b0;
          nxt_done      = 1'b0;
          nxt_state     = ST_DATA;
        end
      end
      ST_DATA: begin
        if (head_valid) begin
          nxt_wreq.data  = head.data;
          nxt_wreq.cache = cache_user_ff[MRD_CACHE_LSB +: 4];
          nxt_wreq.user  = cache_user_ff[MRD_USERW_LSB +: 4];
          // Sideband is trusted to hold for the packet, so any beat will do
          nxt_dest       = head.dest;
          nxt_id         = head.id;
          nxt_user       = head.user;
          nxt_beat_last  = head.last;
          nxt_in_pkt     = !head.last;
          nxt_state      = ST_WRITE;
        end
      end
      ST_WRITE: begin
        if (m_ready_i) begin
          nxt_state = ST_RESP;
        end
      end
      ST_RESP: begin
        if (m_bvalid_i) begin
          if (m_bresp_i == MRD_RESP_SLVERR) begin
            nxt_se    = 1'b1;
            nxt_state = ST_STS;
          end else if (m_bresp_i == MRD_RESP_DECERR) begin
            nxt_de    = 1'b1;
            nxt_state = ST_STS;
          end else if (beat_last_ff || desc_full) begin
            // Packet length must match the programmed geometry exactly
            nxt_eop   = beat_last_ff && desc_full;
            nxt_ie    = !(beat_last_ff && desc_full);
            nxt_state = ST_STS;
          end else if (line_end) begin
            nxt_byte_cnt  = '0;
            nxt_lines     = lines_ff + 1'b1;
            nxt_line_base = line_base_ff + {16'h0000, stride_cnt_ff[MRD_STRIDE_LSB +: 16]};
            nxt_wreq.addr = nxt_line_base;
            nxt_state     = ST_DATA;
          end else begin
            nxt_byte_cnt  = next_bytes;
            nxt_wreq.addr = wreq_ff.addr + MRD_BEAT_BYTES;
            nxt_state     = ST_DATA;
          end
          // Flags land this edge, so the status word is built one cycle later
          if (nxt_state == ST_STS) begin
            nxt_wreq.addr = desc_addr_ff + MRD_STS_OFFSET;
            nxt_state     = ST_PREP;
          end
        end
      end
      ST_PREP: begin
        // Request fields must be settled before valid rises
        nxt_wreq.data  = sts_word;
        nxt_wreq.cache = cache_user_ff[MRD_CACHE_LSB +: 4];
        nxt_wreq.user  = cache_user_ff[MRD_USERW_LSB +: 4];
        nxt_state      = ST_STS;
      end
      ST_STS: begin
        if (m_ready_i) begin
          nxt_last_sts = wreq_ff.data;
          nxt_state    = ST_SRESP;
        end
      end
      ST_SRESP: begin
        if (m_bvalid_i) begin
          nxt_done  = 1'b1;
          nxt_state = (ie_ff || se_ff || de_ff || m_bresp_i[1]) ? ST_HALT : ST_IDLE;
        end
      end
      ST_HALT: begin
        // Engine stays frozen until software clears the halt
        if (clear_req) begin
          nxt_in_pkt = 1'b0;
          nxt_state  = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff     <= ST_IDLE;
      wreq_ff      <= '0;
      line_base_ff <= MRD_RST_WORD;
      byte_cnt_ff  <= '0;
      lines_ff     <= '0;
      dest_ff      <= '0;
      id_ff        <= '0;
      user_ff      <= '0;
      beat_last_ff <= 1'b0;
      in_pkt_ff    <= 1'b0;
      sop_ff       <= 1'b0;
      eop_ff       <= 1'b0;
      ie_ff        <= 1'b0;
      se_ff        <= 1'b0;
      de_ff        <= 1'b0;
      done_ff      <= 1'b0;
      last_sts_ff  <= MRD_RST_WORD;
    end else begin
      state_ff     <= nxt_state;
      wreq_ff      <= nxt_wreq;
      line_base_ff <= nxt_line_base;
      byte_cnt_ff  <= nxt_byte_cnt;
      lines_ff     <= nxt_lines;
      dest_ff      <= nxt_dest;
      id_ff        <= nxt_id;
      user_ff      <= nxt_user;
      beat_last_ff <= nxt_beat_last;
      in_pkt_ff    <= nxt_in_pkt;
      sop_ff       <= nxt_sop;
      eop_ff       <= nxt_eop;
      ie_ff        <= nxt_ie;
      se_ff        <= nxt_se;
      de_ff        <= nxt_de;
      done_ff      <= nxt_done;
      last_sts_ff  <= nxt_last_sts;
    end
  end

endmodule : mrd_rx_status

//--- test/mrd_rx_props.sv
`timescale 1ns/1ps
module mrd_rx_props
  import mrd_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic        wb_ack_o,
  input  wire logic        s_tvalid_i,
  input  wire logic        s_tready_o,
  input  wire logic [4:0]  s_tdest_i,
  input  wire logic [4:0]  s_tid_i,
  input  wire logic [3:0]  s_tuser_i,
  input  wire logic [31:0] m_awaddr_o,
  input  wire logic [3:0]  m_awcache_o,
  input  wire logic [31:0] m_wdata_o,
  input  wire logic        m_valid_o,
  input  wire logic        m_ready_i,
  input  wire logic        m_bvalid_i,
  input  wire logic [1:0]  m_bresp_i,
  input  wire logic        m_bready_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [31:0] desc_ff;
  logic [3:0]  cache_ff;
  logic [13:0] tag_ff;
  logic        se_ff;
  logic        de_ff;
  logic        sts;
  logic        wr;
  assign wr  = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  assign sts = m_valid_o && (m_awaddr_o == desc_ff + MRD_STS_OFFSET);
  //////////////////////////////////////////////////////////////////////////////
  // Shadow of what software and the stream handed over; errors stick until status
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      desc_ff  <= 32'h0;
      cache_ff <= 4'h0;
      tag_ff   <= 14'h0;
      se_ff    <= 1'b0;
      de_ff    <= 1'b0;
    end else begin
      if (wr && wb_adr_i == MRD_REG_DESC_ADDR) desc_ff <= wb_dat_i;
      if (wr && wb_adr_i == MRD_REG_CACHE_USER) cache_ff <= wb_dat_i[27:24];
      if (s_tvalid_i && s_tready_o) tag_ff <= {s_tuser_i, s_tid_i, s_tdest_i};
      if (sts && m_ready_i) begin
        se_ff <= 1'b0;
        de_ff <= 1'b0;
      end else if (m_bvalid_i && m_bready_o) begin
        se_ff <= se_ff | (m_bresp_i == MRD_RESP_SLVERR);
        de_ff <= de_ff | (m_bresp_i == MRD_RESP_DECERR);
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  AST_WB_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse one cycle after request");
  AST_REQ_HOLD: assert property (m_valid_o && !m_ready_i |=> m_valid_o && $stable(m_awaddr_o)
    && $stable(m_wdata_o)) else $error("write request changed before taken");
  AST_CACHE: assert property (m_valid_o |-> m_awcache_o == cache_ff)
    else $error("cache bits differ from descriptor");
  AST_RSVD: assert property (sts |-> (m_wdata_o & 32'h03f0_e0e0) == 32'h0)
    else $error("reserved status bits not zero");
  AST_CMP: assert property (sts |-> m_wdata_o[31])
    else $error("status written without completion bit");
  AST_DEST: assert property (sts |-> m_wdata_o[4:0] == tag_ff[4:0])
    else $error("routing value not captured");
  AST_ID: assert property (sts |-> m_wdata_o[12:8] == tag_ff[9:5])
    else $error("stream identifier not captured");
  AST_USER: assert property (sts |-> m_wdata_o[19:16] == tag_ff[13:10])
    else $error("user sideband not captured");
  AST_SE: assert property (sts |-> m_wdata_o[29] == se_ff)
    else $error("target error bit wrong");
  AST_DE: assert property (sts |-> m_wdata_o[30] == de_ff)
    else $error("decode error bit wrong");
  COV_STS: cover property (sts && m_ready_i);
  COV_ERR: cover property (sts && se_ff);
  COV_FULL: cover property (s_tvalid_i && !s_tready_o);
endmodule : mrd_rx_props
bind mrd_rx_status mrd_rx_props u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_i, .wb_ack_o, .s_tvalid_i, .s_tready_o, .s_tdest_i, .s_tid_i, .s_tuser_i,
  .m_awaddr_o, .m_awcache_o, .m_wdata_o, .m_valid_o, .m_ready_i, .m_bvalid_i, .m_bresp_i,
  .m_bready_o);

//--- test/mrd_mem_model.sv
`timescale 1ns/1ps
module mrd_mem_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       slow_i,
  input  wire logic [1:0] err_i,
  input  wire logic       valid_i,
  output logic            ready_o,
  output logic            bvalid_o,
  output logic [1:0]      bresp_o,
  input  wire logic       bready_i
);
  logic [2:0] dly_ff;
  logic [1:0] rsp_ff;
  logic       pend_ff;
  logic       tick_ff;
  // Response code is latched at acceptance, so the bench may clear err_i at that edge
  always @(posedge clk_i) begin
    if (rst_i) begin
      {dly_ff, rsp_ff, pend_ff, tick_ff} <= 7'h0;
      {ready_o, bvalid_o, bresp_o} <= 4'h0;
    end else begin
      tick_ff <= ~tick_ff;
      ready_o <= ~slow_i | tick_ff;
      // Idle response lines toggle so a stale code is never mistaken for a fresh one
      if (!bvalid_o) bresp_o <= ~bresp_o;
      if (bvalid_o && bready_i) bvalid_o <= 1'b0;
      if (valid_i && ready_o) begin
        pend_ff <= 1'b1;
        dly_ff  <= slow_i ? 3'h3 : 3'h0;
        rsp_ff  <= err_i;
      end else if (pend_ff && dly_ff != 3'h0) begin
        dly_ff <= dly_ff - 3'h1;
      end else if (pend_ff) begin
        pend_ff  <= 1'b0;
        bvalid_o <= 1'b1;
        bresp_o  <= rsp_ff;
      end
    end
  end
endmodule : mrd_mem_model

//--- test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import mrd_pkg::*;
  logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, s_valid, s_last, s_ready;
  logic        m_valid, m_ready, b_valid, b_ready, slow, mon_en;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel, s_user, m_cache, m_user;
  logic [4:0]  s_dest, s_id;
  logic [1:0]  b_resp, err;
  logic [31:0] wb_wdat, wb_rdat, s_data, m_addr, m_data, q, k, nb, bpl, stride, buf_a;
  int          num_errors, n_tests, cyc_cnt;
  mrd_rx_status uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .s_tdata_i(s_data), .s_tvalid_i(s_valid),
    .s_tlast_i(s_last), .s_tdest_i(s_dest), .s_tid_i(s_id), .s_tuser_i(s_user),
    .s_tready_o(s_ready), .m_awaddr_o(m_addr), .m_awcache_o(m_cache), .m_awuser_o(m_user),
    .m_wdata_o(m_data), .m_valid_o(m_valid), .m_ready_i(m_ready), .m_bvalid_i(b_valid),
    .m_bresp_i(b_resp), .m_bready_o(b_ready));
  mrd_mem_model u_mem (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .err_i(err),
    .valid_i(m_valid), .ready_o(m_ready), .bvalid_o(b_valid), .bresp_o(b_resp),
    .bready_i(b_ready));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic results();
    $display("errors %0d comparisons %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat, wb_sel} <= {2'b11, w, a, d, 4'hf};
    @(posedge clk_i);
    while (wb_ack !== 1'b1) @(posedge clk_i);
    q = wb_rdat;
    {wb_cyc, wb_stb} <= 2'b00;
    @(posedge clk_i);
  endtask : wb
  // Sideband stays untouched for the whole packet
  task automatic push(input logic [31:0] n, input logic lst);
    for (logic [31:0] i = 0; i < n; i++) begin
      {s_valid, s_data, s_last} <= {1'b1, 32'hd000_0000 + i, lst && i == n - 1};
      @(posedge clk_i);
      while (s_ready !== 1'b1) @(posedge clk_i);
    end
    s_valid <= 1'b0;
    s_data  <= ~s_data;
  endtask : push
  task automatic prog(input logic [31:0] sc, input logic [31:0] ls);
    wb(1'b1, MRD_REG_DESC_ADDR, 32'h200);
    wb(1'b1, MRD_REG_BUF_ADDR, buf_a);
    wb(1'b1, MRD_REG_CACHE_USER, 32'h0300_0000);
    wb(1'b1, MRD_REG_STRIDE_CNT, sc);
    wb(1'b1, MRD_REG_LINE_SIZE, ls);
  endtask : prog
  task automatic run();
    k = 32'h0;
    wb(1'b1, MRD_REG_CTRL, 32'h1);
    q = 32'h0;
    for (int i = 0; i < 400 && q[2:1] == 2'b00; i++) wb(1'b0, MRD_REG_STATE, 32'h0);
    check({31'h0, q[2:1] == 2'b00}, 32'h0);
  endtask : run
  //////////////////////////////////////////////////////////////////////////////
  // While mon_en is set, each accepted write is checked against the 2-D address walk, then the status address
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 30000) begin
      num_errors++;
      results();
    end
    if (m_valid && m_ready) err <= 2'h0;
    if (m_valid && m_ready && mon_en) begin
      check({24'h0, m_cache, m_user}, 32'h0000_0030);
      if (k < nb) begin
        check(m_addr, buf_a + (k / bpl) * stride + (k % bpl) * 32'h4);
        check(m_data, 32'hd000_0000 + k);
      end else check(m_addr, 32'h200 + MRD_STS_OFFSET);
      k <= k + 32'h1;
    end
  end
  initial begin
    {rst_i, wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wdat} = {4'b1000, 44'h0};
    {s_valid, s_last, s_data, s_dest, s_id, s_user} = {2'b00, 32'h0, 5'h15, 5'h0a, 4'h9};
    {slow, err, mon_en, num_errors, n_tests, cyc_cnt} = {4'b1001, 96'h0};
    {k, nb, bpl, stride, buf_a} = {32'h0, 32'd32, 32'd16, 32'h100, 32'h1000};
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, MRD_REG_LAST_STS, 32'h0);
    check(q, MRD_RST_WORD);
    wb(1'b0, 8'hf0, 32'h0);
    check(q, 32'h0);
    prog(32'h0010_0100, 32'h40);
    // Engine idle, so 32 beats must fill the buffer and stop the stream
    push(32'd32, 1'b1);
    #1 check({31'h0, s_ready}, 32'h0);
    run();
    check(k, 32'd33);
    wb(1'b0, MRD_REG_LAST_STS, 32'h0);
    check(q, {4'h8, 2'b11, 6'h0, s_user, 3'h0, s_id, 3'h0, s_dest});
    {slow, nb, bpl} = {1'b0, 32'd1, 32'd1};
    for (logic [31:0] e = 0; e < 3; e++) begin
      err    <= e == 0 ? MRD_RESP_SLVERR : e == 1 ? MRD_RESP_DECERR : 2'h0;
      mon_en <= e < 2;
      s_dest <= e[4:0];
      prog(e == 2 ? 32'h0010_0100 : 32'h0008_0100, 32'h4);
      push(32'd1, 1'b1);
      run();
      wb(1'b0, MRD_REG_LAST_STS, 32'h0);
      check({26'h0, q[31:26]}, {26'h0, e == 0 ? 6'h2a : e == 1 ? 6'h32 : 6'h26});
      wb(1'b0, MRD_REG_STATE, 32'h0);
      check({31'h0, q[1]}, 32'h1);
      wb(1'b1, MRD_REG_CTRL, 32'h2);
      wb(1'b0, MRD_REG_STATE, 32'h0);
      check({31'h0, q[1]}, 32'h0);
    end
    results();
  end
endmodule : tb_top
